// ==== logic/vtt_consts.svh ====
// Offsets, field positions, reset values and timing counts
`ifndef VTT_CONSTS_SVH
`define VTT_CONSTS_SVH
`define VTT_FRAME_LAST 9'h1AB
`define VTT_POS_V5 9'h000
`define VTT_POS_J2 9'h06B
`define VTT_POS_K4 9'h141
`define VTT_PERSIST_LAST 3'h4
`define VTT_TI_LAST 2'h2
`define VTT_OFF_CTRL 8'h00
`define VTT_OFF_STAT 8'h04
`define VTT_OFF_NBC 8'h08
`define VTT_OFF_FBC 8'h0C
`define VTT_TRACE_PAGE 2'h1
`define VTT_CTRL_RST 32'h00010001
`define VTT_C_MON 0
`define VTT_C_RDIREP 1
`define VTT_C_SSFREP 2
`define VTT_C_MISMATCH_CHECK_DISABLE 3
`define VTT_C_K4SEL 4
`define VTT_C_EXP_LSB 8
`define VTT_C_THR_LSB 16
`define VTT_ALL_ONES 8'hFF
`define VTT_CLK_NS 5
`define VTT_AIS_US 1000
`define VTT_AIS_CYC ((`VTT_AIS_US * 1000) / `VTT_CLK_NS)
`endif

// ==== logic/vtt_pkg.sv ====
// Types shared by the VC-2 trail termination files
package vtt_pkg;
  typedef enum logic [1:0] {VTT_HUNT = 2'b01, VTT_SYNC = 2'b10} vtt_sync_t;
endpackage

// ==== logic/vtt_mem_if.sv ====
// Carrier between the trail termination and its trace memory
`timescale 1ns/1ps
interface vtt_mem_if #(parameter int AW = 4, parameter int DW = 8);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_data;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_data;
  modport user (output wr_en, wr_addr, wr_data, a_addr, b_addr,
    input a_data, b_data);
  modport mem (input wr_en, wr_addr, wr_data, a_addr, b_addr,
    output a_data, b_data);
endinterface

// ==== logic/vtt_mem.sv ====
// Transmitted trace memory: one write port, two registered read ports
`timescale 1ns/1ps
module vtt_mem #(parameter int AW = 4, parameter int DW = 8) (
  // System
  input wire logic mclk,
  input wire logic resetn,
  // Memory access
  vtt_mem_if.mem mp
);
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge mclk)
  begin
    if (mp.wr_en)
    begin
      cells[mp.wr_addr] <= mp.wr_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mp.a_data <= '0;
      mp.b_data <= '0;
    end
    else
    begin
      mp.a_data <= cells[mp.a_addr];
      mp.b_data <= cells[mp.b_addr];
    end
  end
endmodule

// ==== logic/vtt_top.sv ====
// VC-2 path trail termination: source and sink over a sampled link clock
`timescale 1ns/1ps
`include "vtt_consts.svh"
module vtt_top import vtt_pkg::*; #(
  parameter int AIS_LIMIT_CYC = `VTT_AIS_CYC
) (
  // System
  input wire logic mclk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link clock and source input (adapted information)
  input wire logic link_clk,
  input wire logic [7:0] src_ai_d,
  input wire logic src_ai_fs,
  // Source output (characteristic information)
  output logic [7:0] src_ci_d,
  output logic src_ci_fs,
  // Sink input (characteristic information)
  input wire logic [7:0] snk_ci_d,
  input wire logic snk_ci_fs,
  input wire logic snk_ci_ssf,
  // Sink output (adapted information)
  output logic [7:0] snk_ai_d,
  output logic snk_ai_fs,
  output logic snk_ai_tsf,
  output logic snk_ai_tsd,
  // Management timing and equipment status
  input wire logic one_second,
  input wire logic equipment_defect
);
  function automatic logic [1:0] bip2(input logic [7:0] b);
    return {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
  endfunction

  function automatic logic [8:0] pos_step(input logic [8:0] p);
    return (p == `VTT_FRAME_LAST) ? 9'h000 : p + 9'h001;
  endfunction

  // Returns {defect, count}: five agreeing frames flip the defect
  function automatic logic [3:0] persist(input logic cur, input logic cond,
    input logic [2:0] cnt);
    logic [3:0] r;
    r = {cur, 3'h0};
    if (cond != cur)
    begin
      r = (cnt == `VTT_PERSIST_LAST) ? {cond, 3'h0} : {cur, cnt + 3'h1};
    end
    return r;
  endfunction

  vtt_mem_if #(.AW(4), .DW(8)) mif ();
  vtt_mem #(.AW(4), .DW(8)) u_mem (.mclk(mclk), .resetn(resetn), .mp(mif));

  // Link synchroniser: clock and data pass two stages together
  logic [19:0] lk_s1;
  logic [19:0] lk_s2;
  logic lk_clk_d;
  logic tick;
  logic s_fs;
  logic [7:0] s_d;
  logic k_fs;
  logic k_ssf;
  logic [7:0] k_d;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      lk_s1 <= '0;
      lk_s2 <= '0;
      lk_clk_d <= 1'b0;
    end
    else
    begin
      lk_s1 <= {link_clk, src_ai_fs, src_ai_d, snk_ci_fs, snk_ci_ssf,
        snk_ci_d};
      lk_s2 <= lk_s1;
      lk_clk_d <= lk_s2[19];
    end
  end

  assign tick = lk_s2[19] & ~lk_clk_d;
  assign s_fs = lk_s2[18];
  assign s_d = lk_s2[17:10];
  assign k_fs = lk_s2[9];
  assign k_ssf = lk_s2[8];
  assign k_d = lk_s2[7:0];

  // Control register and defect state
  logic [31:0] ctrl;
  logic uneq;
  logic rdi_def;
  logic deg;
  logic tim;
  logic mon;
  logic ais;
  logic tsf;
  logic rdi_req;
  logic near_err;
  logic far_err;
  logic [7:0] ti_acc;
  logic [7:0] exp_ti;

  assign mon = ctrl[`VTT_C_MON];
  assign exp_ti = ctrl[`VTT_C_EXP_LSB +: 8];
  assign tim = ~ctrl[`VTT_C_MISMATCH_CHECK_DISABLE] & (ti_acc != exp_ti);
  assign ais = uneq | tim;
  assign tsf = k_ssf | uneq | tim;
  assign rdi_req = tsf;
  assign snk_ai_tsf = tsf;
  assign snk_ai_tsd = deg;

  // Source path
  vtt_sync_t src_state, next_src_state;
  logic [8:0] src_pos, next_src_pos, src_p;
  logic [1:0] src_acc, next_src_acc;
  logic [3:0] src_mf, next_src_mf;
  logic rei_flag, next_rei_flag;
  logic [7:0] next_src_ci_d, src_byte;
  logic next_src_ci_fs;
  logic src_live;

  assign src_live = (src_state == VTT_SYNC) | s_fs;
  assign src_p = s_fs ? `VTT_POS_V5 : src_pos;
  assign mif.b_addr = src_mf;

  always_comb
  begin
    next_src_state = src_state;
    next_src_pos = src_pos;
    next_src_acc = src_acc;
    next_src_mf = src_mf;
    next_src_ci_d = src_ci_d;
    next_src_ci_fs = src_ci_fs;
    next_rei_flag = rei_flag;
    src_byte = s_d;
    case (src_state)
      VTT_HUNT: if (tick & s_fs) next_src_state = VTT_SYNC;
      VTT_SYNC: next_src_state = VTT_SYNC;
      default: next_src_state = VTT_HUNT;
    endcase
    if (tick & src_live)
    begin
      if (src_p == `VTT_POS_V5)
      begin
        // V5: BIP-2, remote error, reserved, label from adapted side, RDI
        src_byte = {src_acc, rei_flag, 1'b0, s_d[3:1], rdi_req};
        next_rei_flag = 1'b0;
        next_src_mf = src_mf + 4'h1;
      end
      else if (src_p == `VTT_POS_J2)
      begin
        src_byte = mif.b_data;
      end
      else if (src_p == `VTT_POS_K4)
      begin
        // Bit 8 carries no defined value and is sent as zero
        src_byte = {s_d[7:4], {3{ctrl[`VTT_C_K4SEL]}}, 1'b0};
      end
      next_src_acc = ((src_p == `VTT_POS_V5) ? 2'h0 : src_acc)
        ^ bip2(src_byte);
      next_src_pos = pos_step(src_p);
    end
    if (tick)
    begin
      next_src_ci_d = src_byte;
      next_src_ci_fs = s_fs;
    end
    if (near_err)
    begin
      next_rei_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      src_state <= VTT_HUNT;
      src_pos <= 9'h000;
      src_acc <= 2'h0;
      src_mf <= 4'h0;
      rei_flag <= 1'b0;
      src_ci_d <= 8'h00;
      src_ci_fs <= 1'b0;
    end
    else
    begin
      src_state <= next_src_state;
      src_pos <= next_src_pos;
      src_acc <= next_src_acc;
      src_mf <= next_src_mf;
      rei_flag <= next_rei_flag;
      src_ci_d <= next_src_ci_d;
      src_ci_fs <= next_src_ci_fs;
    end
  end

  // Sink path
  vtt_sync_t snk_state, next_snk_state;
  logic [8:0] snk_pos, next_snk_pos, snk_p;
  logic [1:0] snk_acc, next_snk_acc;
  logic snk_full, next_snk_full;
  logic [7:0] ti_cand, next_ti_cand, next_ti_acc;
  logic [1:0] ti_cnt, next_ti_cnt;
  logic [2:0] uneq_cnt, rdi_cnt;
  logic [3:0] uneq_upd, rdi_upd;
  logic [7:0] next_snk_ai_d;
  logic next_snk_ai_fs;
  logic snk_live;

  assign snk_live = (snk_state == VTT_SYNC) | k_fs;
  assign snk_p = k_fs ? `VTT_POS_V5 : snk_pos;

  always_comb
  begin
    next_snk_state = snk_state;
    next_snk_pos = snk_pos;
    next_snk_acc = snk_acc;
    next_snk_full = snk_full;
    next_ti_cand = ti_cand;
    next_ti_cnt = ti_cnt;
    next_ti_acc = ti_acc;
    next_snk_ai_d = snk_ai_d;
    next_snk_ai_fs = snk_ai_fs;
    uneq_upd = {uneq, uneq_cnt};
    rdi_upd = {rdi_def, rdi_cnt};
    near_err = 1'b0;
    far_err = 1'b0;
    case (snk_state)
      VTT_HUNT: if (tick & k_fs) next_snk_state = VTT_SYNC;
      VTT_SYNC: next_snk_state = VTT_SYNC;
      default: next_snk_state = VTT_HUNT;
    endcase
    if (tick & snk_live)
    begin
      if (snk_p == `VTT_POS_V5)
      begin
        next_snk_full = 1'b1;
        near_err = snk_full & (k_d[7:6] != snk_acc);
        far_err = k_d[5];
        uneq_upd = persist(uneq, k_d[3:1] == 3'h0, uneq_cnt);
        rdi_upd = persist(rdi_def, k_d[0], rdi_cnt);
      end
      else if (snk_p == `VTT_POS_J2)
      begin
        // Trace accepted after four identical frames
        if (k_d != ti_cand)
        begin
          next_ti_cand = k_d;
          next_ti_cnt = 2'h0;
        end
        else if (ti_cnt == `VTT_TI_LAST)
        begin
          next_ti_acc = k_d;
        end
        else
        begin
          next_ti_cnt = ti_cnt + 2'h1;
        end
      end
      next_snk_acc = ((snk_p == `VTT_POS_V5) ? 2'h0 : snk_acc)
        ^ bip2(k_d);
      next_snk_pos = pos_step(snk_p);
    end
    if (tick)
    begin
      next_snk_ai_d = ais ? `VTT_ALL_ONES : k_d;
      next_snk_ai_fs = k_fs;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      snk_state <= VTT_HUNT;
      snk_pos <= 9'h000;
      snk_acc <= 2'h0;
      snk_full <= 1'b0;
      ti_cand <= 8'h00;
      ti_cnt <= 2'h0;
      ti_acc <= 8'h00;
      uneq <= 1'b0;
      uneq_cnt <= 3'h0;
      rdi_def <= 1'b0;
      rdi_cnt <= 3'h0;
      snk_ai_d <= 8'h00;
      snk_ai_fs <= 1'b0;
    end
    else
    begin
      snk_state <= next_snk_state;
      snk_pos <= next_snk_pos;
      snk_acc <= next_snk_acc;
      snk_full <= next_snk_full;
      ti_cand <= next_ti_cand;
      ti_cnt <= next_ti_cnt;
      ti_acc <= next_ti_acc;
      {uneq, uneq_cnt} <= uneq_upd;
      {rdi_def, rdi_cnt} <= rdi_upd;
      snk_ai_d <= next_snk_ai_d;
      snk_ai_fs <= next_snk_ai_fs;
    end
  end

  // Per-second performance monitoring and degrade detection
  logic [15:0] near_acc, far_acc, near_cnt, far_cnt;
  logic [15:0] next_near_acc, next_far_acc, near_sum, far_sum;
  logic [15:0] next_near_cnt, next_far_cnt;
  logic nds_acc, fds_acc, near_ds, far_ds, next_deg;
  logic next_nds_acc, next_fds_acc, next_near_ds, next_far_ds;

  assign near_sum = near_acc + {15'h0000, near_err};
  assign far_sum = far_acc + {15'h0000, far_err};

  always_comb
  begin
    next_near_acc = near_sum;
    next_far_acc = far_sum;
    next_nds_acc = nds_acc | tsf | equipment_defect;
    next_fds_acc = fds_acc | rdi_def;
    next_near_cnt = near_cnt;
    next_far_cnt = far_cnt;
    next_near_ds = near_ds;
    next_far_ds = far_ds;
    next_deg = deg;
    if (one_second)
    begin
      next_near_cnt = near_sum;
      next_far_cnt = far_sum;
      next_near_ds = next_nds_acc;
      next_far_ds = next_fds_acc;
      next_deg = near_sum >= ctrl[`VTT_C_THR_LSB +: 16];
      next_near_acc = 16'h0000;
      next_far_acc = 16'h0000;
      next_nds_acc = 1'b0;
      next_fds_acc = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      near_acc <= 16'h0000;
      far_acc <= 16'h0000;
      near_cnt <= 16'h0000;
      far_cnt <= 16'h0000;
      nds_acc <= 1'b0;
      fds_acc <= 1'b0;
      near_ds <= 1'b0;
      far_ds <= 1'b0;
      deg <= 1'b0;
    end
    else
    begin
      near_acc <= next_near_acc;
      far_acc <= next_far_acc;
      near_cnt <= next_near_cnt;
      far_cnt <= next_far_cnt;
      nds_acc <= next_nds_acc;
      fds_acc <= next_fds_acc;
      near_ds <= next_near_ds;
      far_ds <= next_far_ds;
      deg <= next_deg;
    end
  end

  // Correlated faults
  logic uneq_fault, mismatch_fault, degrade_fault, rdef_fault, ssf_fault;
  assign uneq_fault = uneq & mon;
  assign mismatch_fault = tim & ~uneq & mon;
  assign degrade_fault = deg & ~tim & mon;
  assign rdef_fault = rdi_def & ~uneq & ~tim & mon
    & ctrl[`VTT_C_RDIREP];
  assign ssf_fault = k_ssf & mon & ctrl[`VTT_C_SSFREP];

  // AHB-Lite slave: zero wait states, always OKAY
  logic dp_valid, next_dp_valid, dp_write, next_dp_write;
  logic [7:0] dp_addr, next_dp_addr;
  logic dp_mem, next_dp_mem;
  logic [31:0] rdq, next_rdq, next_ctrl;
  logic ap_take;

  assign ap_take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = dp_mem ? {24'h000000, mif.a_data} : rdq;
  assign mif.a_addr = haddr[5:2];
  assign mif.wr_en = dp_valid & dp_write & (dp_addr[7:6] == `VTT_TRACE_PAGE);
  assign mif.wr_addr = dp_addr[5:2];
  assign mif.wr_data = hwdata[7:0];

  always_comb
  begin
    next_dp_valid = ap_take;
    next_dp_write = ap_take & hwrite;
    next_dp_addr = ap_take ? haddr[7:0] : dp_addr;
    next_dp_mem = ap_take & ~hwrite & (haddr[7:6] == `VTT_TRACE_PAGE);
    next_ctrl = ctrl;
    next_rdq = 32'h00000000;
    if (ap_take & ~hwrite)
    begin
      case (haddr[7:0])
        `VTT_OFF_CTRL: next_rdq = ctrl;
        `VTT_OFF_STAT: next_rdq = {8'h00, ti_acc, 7'h00, ssf_fault,
          rdef_fault, degrade_fault, mismatch_fault, uneq_fault,
          rdi_def, deg, tim, uneq};
        `VTT_OFF_NBC: next_rdq = {15'h0000, near_ds, near_cnt};
        `VTT_OFF_FBC: next_rdq = {15'h0000, far_ds, far_cnt};
        default: next_rdq = 32'h00000000;
      endcase
    end
    if (dp_valid & dp_write & (dp_addr == `VTT_OFF_CTRL))
    begin
      next_ctrl = hwdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      dp_mem <= 1'b0;
      rdq <= 32'h00000000;
      ctrl <= `VTT_CTRL_RST;
    end
    else
    begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      dp_mem <= next_dp_mem;
      rdq <= next_rdq;
      ctrl <= next_ctrl;
    end
  end

  // Helper: cycles spent in all-ones action without all-ones data
  logic [17:0] ais_wait;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ais_wait <= 18'h00000;
    else if (ais & (snk_ai_d != `VTT_ALL_ONES))
      ais_wait <= ais_wait + 18'h00001;
    else
      ais_wait <= 18'h00000;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence src_v5_s;
    tick && (src_state == VTT_SYNC) && (src_p == `VTT_POS_V5);
  endsequence
  sequence src_j2_s;
    tick && (src_state == VTT_SYNC) && (src_p == `VTT_POS_J2);
  endsequence
  sequence src_k4_s;
    tick && (src_state == VTT_SYNC) && (src_p == `VTT_POS_K4);
  endsequence

  trace_insert_a: assert property (src_j2_s |=>
    src_ci_d == $past(mif.b_data))
    else $error("J2 byte differs from transmitted trace");
  rei_insert_a: assert property (src_v5_s |=>
    src_ci_d[5] == $past(rei_flag))
    else $error("V5 bit 3 does not carry the remote error");
  rdi_insert_a: assert property (src_v5_s |=>
    src_ci_d[0] == $past(rdi_req))
    else $error("V5 bit 8 does not follow the remote defect request");
  bip_insert_a: assert property (src_v5_s |=>
    src_ci_d[7:6] == $past(src_acc))
    else $error("V5 bits 1-2 do not carry the previous frame parity");
  k4_pattern_a: assert property (src_k4_s |=>
    src_ci_d[3:1] inside {3'h0, 3'h7})
    else $error("K4 bits 5-7 not 000 or 111");
  near_block_a: assert property (near_err |=> rei_flag)
    else $error("Errored block not passed to the source");
  ais_force_a: assert property (tick && ais |=>
    snk_ai_d == `VTT_ALL_ONES)
    else $error("All-ones not output during the action");
  ais_bound_a: assert property (ais_wait < 18'(AIS_LIMIT_CYC))
    else $error("All-ones insertion too late");
  fault_mon_a: assert property (!mon |->
    !(uneq_fault || mismatch_fault || degrade_fault || rdef_fault
    || ssf_fault))
    else $error("Fault reported with monitoring off");
  second_latch_a: assert property (one_second |=>
    near_cnt == $past(near_sum))
    else $error("Near-end block count not latched at second");
endmodule

// ==== verification/vtt_link_model.sv ====
// Far-side model: frames octets on the link for source and sink
`timescale 1ns/1ps
module vtt_link_model (
  // System
  input wire logic mclk,
  input wire logic resetn,
  // Overhead controls
  input wire logic [2:0] label,
  input wire logic rei,
  input wire logic rdi,
  input wire logic bip_err,
  // Link
  output logic link_clk,
  output logic [7:0] d,
  output logic fs
);
  logic [8:0] pos;
  logic [1:0] acc;
  logic [7:0] b;
  initial link_clk = 1'b0;
  always #24 link_clk = ~link_clk;
  initial
  begin
    d = 8'h00;
    fs = 1'b0;
    pos = 9'h000;
    acc = 2'b00;
    wait (resetn === 1'b1);
    repeat (4) @(negedge link_clk);
    forever
    begin
      @(posedge mclk);
      case (pos)
        9'h000: b = {bip_err ? ~acc : acc, rei, 1'b0, label, rdi};
        9'h06B: b = 8'h3C;
        9'h141: b = 8'h9D;
        default: b = pos[7:0] ^ 8'h5A;
      endcase
      // Parity of the frame just sent, V5 included
      acc = (pos == 9'h000) ? 2'b00 : acc;
      acc = acc ^ {^(b & 8'hAA), ^(b & 8'h55)};
      d <= b;
      fs <= (pos == 9'h000);
      pos = (pos == 9'h1AB) ? 9'h000 : pos + 9'h001;
      @(negedge link_clk);
    end
  end
endmodule

// ==== verification/vtt_top_tb.sv ====
// Self-checking bench for the VC-2 trail termination
`timescale 1ns/1ps
module vtt_top_tb;
  logic mclk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'b00, acc;
  logic hreadyout, hresp, snk_fs, link_clk, fs, src_ci_fs, tsf, tsd, v5_rdi;
  logic [7:0] ci_d, src_ci_d, snk_ai_d;
  logic ssf = 1'b0, one_second = 1'b0, eqd = 1'b0;
  logic rei = 1'b0, rdi = 1'b0, bip_err = 1'b0;
  logic [2:0] label = 3'b010, k4_exp = 3'b111;
  int err_count = 0, cmp_count = 0, nfs = 0, spos = 0, rei_cnt = 0;
  localparam logic [31:0] CTRL = 32'h00013C17;
  localparam logic [31:0] SM = 32'h00FF01FF;
  always #2.5 mclk = ~mclk;
  vtt_top dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_clk(link_clk), .src_ai_d(ci_d), .src_ai_fs(fs),
    .src_ci_d(src_ci_d), .src_ci_fs(src_ci_fs), .snk_ci_d(ci_d),
    .snk_ci_fs(fs), .snk_ci_ssf(ssf), .snk_ai_d(snk_ai_d),
    .snk_ai_fs(snk_fs), .snk_ai_tsf(tsf), .snk_ai_tsd(tsd),
    .one_second(one_second), .equipment_defect(eqd));
  vtt_link_model far (.mclk(mclk), .resetn(resetn), .label(label),
    .rei(rei), .rdi(rdi), .bip_err(bip_err), .link_clk(link_clk),
    .d(ci_d), .fs(fs));
  task automatic compare(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single transfer; an idle cycle first keeps read-after-write legal
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic rchk(input string what, input logic [31:0] a,
    input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    compare(what, exp, rd & m);
    compare("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge fs);
  endtask
  task automatic sec;
    @(posedge mclk);
    one_second <= 1'b1;
    @(posedge mclk);
    one_second <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watches the source output frame by frame
  always @(negedge link_clk)
    if (resetn === 1'b1)
    begin
      if (src_ci_fs === 1'b1)
      begin
        if (nfs > 0)
          compare("v5 parity", {30'h0, acc},
            {30'h0, src_ci_d[7:6]});
        nfs++;
        spos = 0;
        acc = 2'b00;
        v5_rdi = src_ci_d[0];
        rei_cnt += int'(src_ci_d[5]);
      end
      else
        spos++;
      if (nfs > 0 && spos == 107)
        compare("j2", 32'hC3, {24'h0, src_ci_d});
      if (nfs > 0 && spos == 321)
        compare("k4", {29'h0, k4_exp},
          {29'h0, src_ci_d[3:1]});
      acc ^= {^(src_ci_d & 8'hAA), ^(src_ci_d & 8'h55)};
      compare("sink fs", {31'h0, fs}, {31'h0, snk_fs});
    end
  initial
  begin
    #490000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rchk("ctrl reset", 32'h00, 32'hFFFFFFFF, 32'h00010001);
    bus(1'b1, 32'h00, CTRL);
    for (int i = 0; i < 16; i++)
      bus(1'b1, 32'h40 + 32'(4 * i), 32'hFFFFFFC3);
    rchk("trace word", 32'h7C, 32'hFFFFFFFF, 32'h000000C3);
    rchk("unmapped", 32'hF0, 32'hFFFFFFFF, 32'h0);
    frames(4);
    rchk("status clean", 32'h04, SM, 32'h003C0000);
    sec;
    rdi <= 1'b1;
    rei <= 1'b1;
    bip_err <= 1'b1;
    frames(1);
    bip_err <= 1'b0;
    frames(1);
    rei <= 1'b0;
    frames(4);
    compare("rei sent", 32'h1, 32'(rei_cnt));
    sec;
    rchk("near count", 32'h08, 32'hFFFFFFFF, 32'h1);
    rchk("far count", 32'h0C, 32'hFFFF, 32'h2);
    rchk("remote", 32'h04, SM, 32'h003C00CC);
    compare("degrade", 32'h1, {31'h0, tsd});
    label <= 3'b000;
    frames(6);
    rchk("unequipped", 32'h04, SM, 32'h003C005D);
    compare("fail action", 32'h1, {31'h0, tsf});
    repeat (3) @(negedge link_clk);
    compare("rdi request", 32'h1, {31'h0, v5_rdi});
    compare("all ones", 32'hFF, {24'h0, snk_ai_d});
    sec;
    rchk("near second", 32'h08, 32'hFFFFFFFF, 32'h00010000);
    bus(1'b1, 32'h00, 32'h00013C06);
    k4_exp = 3'b000;
    rchk("monitor off", 32'h04, SM, 32'h003C0009);
    ssf <= 1'b1;
    bus(1'b1, 32'h00, CTRL);
    k4_exp = 3'b111;
    rchk("server fail", 32'h04, SM, 32'h003C0119);
    ssf <= 1'b0;
    label <= 3'b010;
    rdi <= 1'b0;
    frames(6);
    rchk("recovered", 32'h04, SM, 32'h003C0000);
    compare("fail clear", 32'h0, {31'h0, tsf});
    repeat (3) @(negedge link_clk);
    compare("rdi clear", 32'h0, {31'h0, v5_rdi});
    compare("normal data", {24'h0, ci_d}, {24'h0, snk_ai_d});
    bus(1'b1, 32'h00, 32'h00015517);
    rchk("mismatch", 32'h04, SM, 32'h003C0022);
    compare("mismatch fail", 32'h1, {31'h0, tsf});
    bus(1'b1, 32'h00, 32'h0001551F);
    rchk("mismatch off", 32'h04, SM, 32'h003C0000);
    // A clean second with only the equipment defect raised
    sec;
    eqd <= 1'b1;
    sec;
    eqd <= 1'b0;
    rchk("equipment second", 32'h08, 32'hFFFFFFFF, 32'h00010000);
    end_of_test;
  end
endmodule
